// [hw/ctw_watchdog.sv]
// Communication monitor and nibble-toggle watchdog with an AHB-Lite register slave.
// Assumes event inputs are one-cycle pulses from the protocol engine on hclk.
`timescale 1ns/100ps
`default_nettype none

module ctw_watchdog #(
  parameter int unsigned COMM_CYC      = ctw_pkg::COMM_TIMEOUT_CYC,
  parameter int unsigned TOG_CYC       = ctw_pkg::TOG_TIMEOUT_CYC,
  // Profile code that selects nibble mode; this value is arbitrary.
  parameter logic [3:0]  NIBBLE_PROFILE = 4'h5
) (
  input  wire logic        hclk,                // System clock.
  input  wire logic        hresetn,             // Asynchronous reset, active low.
  input  wire logic        hsel,                // Slave select.
  input  wire logic [31:0] haddr,               // Byte address.
  input  wire logic [1:0]  htrans,              // Transfer type.
  input  wire logic        hwrite,              // Write when high.
  input  wire logic [2:0]  hsize,               // Transfer size.
  input  wire logic [31:0] hwdata,              // Write data.
  input  wire logic        hready,              // Bus ready.
  output var  logic [31:0] hrdata,              // Read data.
  output var  logic        hreadyout,           // Slave ready.
  output var  logic        hresp,               // Response, always OKAY.
  input  wire logic        data_xchg_evt,       // Data exchange request processed.
  input  wire logic        nibble_toggle_bit,   // Selector bit of that request.
  input  wire logic        param_write_evt,     // Parameter write request processed.
  input  wire logic        addr_delete_evt,     // Address deletion request received.
  input  wire logic        chip_reset_evt,      // Any other chip reset.
  input  wire logic        param_port_bit0,     // Parameter port bit 0 level.
  output var  logic        red_fault_indicator, // Red fault indicator, high is lit.
  output var  logic        wdg_reset_pulse,     // Forced reset and initialization start.
  output var  logic        data_strobe,         // Data strobe with outputs forced off.
  output var  logic        param_strobe,        // Parameter strobe with outputs forced off.
  output var  logic        xchg_block           // Data exchange refused while high.
);

  typedef struct packed {
    logic [31:0]              rdata;
    logic                     rdy;
    logic                     wr_pend;
    logic [7:0]               wr_addr;
    logic                     always_on;
    logic                     p0gate;
    logic                     nib_sel;
    logic [3:0]               profile;
    logic [4:0]               slave_addr;
    ctw_pkg::ctw_mon_state_t  mon;
    logic                     tog_en;
    logic                     last_tog;
    logic                     block;
    logic                     red;
    logic                     wdg_rst;
    logic                     dstb;
    logic                     pstb;
  } ctw_st_t;

  ctw_st_t q;
  ctw_st_t d;

  logic comm_exp;
  logic tog_exp;
  logic dx_ok;
  logic any_xchg;
  logic wdg_mode;
  logic tog_act;
  logic tog_restart;
  logic comm_fire;
  logic tog_fire;
  logic wdg_fire;
  logic deact;

  function automatic logic addr_nonzero(input logic [4:0] a);
    return a != 5'h00;
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a, input ctw_st_t s,
                                          input logic wm, input logic ta);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == ctw_pkg::CTRL_OFS) begin
      w[ctw_pkg::CTRL_ALWAYS_BIT]                  = s.always_on;
      w[ctw_pkg::CTRL_P0GATE_BIT]                  = s.p0gate;
      w[ctw_pkg::CTRL_NIBBLE_BIT]                  = s.nib_sel;
      w[ctw_pkg::CTRL_PROF_LSB +: 4]               = s.profile;
      w[ctw_pkg::CTRL_ADDR_LSB +: 5]               = s.slave_addr;
    end else if (a == ctw_pkg::STATUS_OFS) begin
      w[ctw_pkg::ST_MON_RUN_BIT]  = (s.mon != ctw_pkg::MON_OFF);
      w[ctw_pkg::ST_FAULT_BIT]    = (s.mon == ctw_pkg::MON_FAULT);
      w[ctw_pkg::ST_WDG_MODE_BIT] = wm;
      w[ctw_pkg::ST_TOG_EN_BIT]   = s.tog_en;
      w[ctw_pkg::ST_TOG_ACT_BIT]  = ta;
      w[ctw_pkg::ST_BLOCK_BIT]    = s.block;
      w[ctw_pkg::ST_LAST_TOG_BIT] = s.last_tog;
    end
    return w;
  endfunction

  assign dx_ok    = data_xchg_evt && !q.block;
  assign any_xchg = dx_ok || param_write_evt;
  assign deact    = chip_reset_evt || addr_delete_evt;

  assign wdg_mode = q.always_on || (q.p0gate && param_port_bit0);

  assign tog_act  = (q.profile == NIBBLE_PROFILE) && q.nib_sel && wdg_mode;

  // selector change restarts the toggle timer.
  assign tog_restart = !q.tog_en || (dx_ok && (nibble_toggle_bit != q.last_tog));

  // communication expiry in watchdog mode forces reset.
  assign comm_fire = (q.mon == ctw_pkg::MON_RUN) && comm_exp && !any_xchg && wdg_mode;
  // toggle expiry forces the same reset.
  assign tog_fire  = q.tog_en && tog_act && tog_exp;
  assign wdg_fire  = comm_fire || tog_fire;

  ctw_timer #(
    .LIMIT (COMM_CYC)
  ) u_comm_timer (
    .clk     (hclk),
    .rst_n   (hresetn),
    .run     (q.mon == ctw_pkg::MON_RUN),
    .restart (any_xchg),
    .expire  (comm_exp)
  );

  ctw_timer #(
    .LIMIT (TOG_CYC)
  ) u_tog_timer (
    .clk     (hclk),
    .rst_n   (hresetn),
    .run     (q.tog_en && tog_act),
    .restart (tog_restart),
    .expire  (tog_exp)
  );

  always_comb begin
    d         = q;
    d.rdy     = 1'b1;
    d.rdata   = 32'h0000_0000;
    d.wr_pend = 1'b0;
    d.wdg_rst = 1'b0;
    d.dstb    = 1'b0;
    d.pstb    = 1'b0;

    // Data phase of a write lands in the control register.
    if (q.wr_pend && (q.wr_addr == ctw_pkg::CTRL_OFS)) begin
      d.always_on  = hwdata[ctw_pkg::CTRL_ALWAYS_BIT];
      d.p0gate     = hwdata[ctw_pkg::CTRL_P0GATE_BIT];
      d.nib_sel    = hwdata[ctw_pkg::CTRL_NIBBLE_BIT];
      d.profile    = hwdata[ctw_pkg::CTRL_PROF_LSB +: 4];
      d.slave_addr = hwdata[ctw_pkg::CTRL_ADDR_LSB +: 5];
    end

    // Address phase; reads answer with zero wait states.
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        d.wr_pend = 1'b1;
        d.wr_addr = haddr[7:0];
      end else begin
        d.rdata = rd_word(haddr[7:0], q, wdg_mode, tog_act);
      end
    end

    unique case (q.mon)
      ctw_pkg::MON_OFF: begin
        if (param_write_evt && addr_nonzero(q.slave_addr)) begin
          d.mon = ctw_pkg::MON_RUN;
        end
      end
      ctw_pkg::MON_RUN: begin
        // An exchange in the expiry cycle wins and restarts the count.
        // timeout lights red indicator, cleared again below by a watchdog-mode forced reset.
        if (comm_exp && !any_xchg) begin
          d.mon = ctw_pkg::MON_FAULT;
          d.red = 1'b1;
        end
      end
      ctw_pkg::MON_FAULT: begin
        if (any_xchg) begin
          d.mon = ctw_pkg::MON_RUN;
          d.red = 1'b0;
        end
      end
      default: begin
        d.mon = ctw_pkg::MON_OFF;
      end
    endcase

    if (!q.tog_en && dx_ok && addr_nonzero(q.slave_addr)) begin
      d.tog_en = 1'b1;
    end
    if (dx_ok) begin
      d.last_tog = nibble_toggle_bit;
    end

    // parameter write lifts the exchange block.
    if (param_write_evt) begin
      d.block = 1'b0;
    end

    // toggle disable by reset or deletion.
    if (deact) begin
      d.mon    = ctw_pkg::MON_OFF;
      d.tog_en = 1'b0;
      d.red    = 1'b0;
    end

    // forced reset sequence, taking priority over a same-cycle unblock.
    if (wdg_fire) begin
      d.wdg_rst = 1'b1;
      d.dstb    = 1'b1;
      d.pstb    = 1'b1;
      d.block   = 1'b1;
      d.mon     = ctw_pkg::MON_OFF;
      d.tog_en  = 1'b0;
      d.red     = 1'b0;
    end
  end

  localparam ctw_st_t ST_RESET = '{
    rdata:      32'h0000_0000,
    rdy:        1'b1,
    wr_pend:    1'b0,
    wr_addr:    8'h00,
    always_on:  ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_ALWAYS_BIT],
    p0gate:     ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_P0GATE_BIT],
    nib_sel:    ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_NIBBLE_BIT],
    profile:    ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_PROF_LSB +: 4],
    slave_addr: ctw_pkg::CTRL_RESET[ctw_pkg::CTRL_ADDR_LSB +: 5],
    mon:        ctw_pkg::MON_OFF,
    tog_en:     1'b0,
    last_tog:   1'b0,
    block:      1'b0,
    red:        1'b0,
    wdg_rst:    1'b0,
    dstb:       1'b0,
    pstb:       1'b0
  };

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  logic hresp_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  assign hrdata              = q.rdata;
  assign hreadyout           = q.rdy;
  assign hresp               = hresp_q;
  assign red_fault_indicator = q.red;
  assign wdg_reset_pulse     = q.wdg_rst;
  assign data_strobe         = q.dstb;
  assign param_strobe        = q.pstb;
  assign xchg_block          = q.block;

  // The checks below watch registered state one clock after its cause.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_led_on_cause: assert property (
    $rose(q.red) |-> $past(comm_exp) && $past(q.mon == ctw_pkg::MON_RUN))
    else $error("Red indicator lit without a monitor timeout.");

  a_led_off_cause: assert property (
    $fell(q.red) |-> $past(any_xchg || deact || wdg_fire))
    else $error("Red indicator cleared without an exchange or reset.");

  a_mon_start: assert property (
    $past(q.mon == ctw_pkg::MON_OFF) && (q.mon == ctw_pkg::MON_RUN)
      |-> $past(param_write_evt) && $past(addr_nonzero(q.slave_addr)))
    else $error("Monitor started without a parameter write at a nonzero address.");

  a_mon_deact: assert property (
    deact |=> (q.mon == ctw_pkg::MON_OFF) && !q.red)
    else $error("Monitor still active after reset or address deletion.");

  a_wdg_comm_rst: assert property (
    comm_fire |=> q.wdg_rst && q.dstb && q.pstb && q.block ##1 !q.wdg_rst)
    else $error("Communication watchdog did not issue one reset pulse.");

  a_block_hold: assert property (
    q.block && !param_write_evt |=> q.block)
    else $error("Exchange block lifted without a parameter write.");

  a_tog_enable: assert property (
    $rose(q.tog_en) |-> $past(dx_ok) && $past(addr_nonzero(q.slave_addr)))
    else $error("Toggle watchdog enabled without a data output event.");

  a_tog_disable: assert property (
    deact |=> !q.tog_en)
    else $error("Toggle watchdog still enabled after reset or deletion.");

  a_tog_fire_rst: assert property (
    tog_fire |=> q.wdg_rst && q.block && !q.tog_en)
    else $error("Toggle watchdog expiry did not force a reset.");

  a_plain_no_rst: assert property (
    (q.mon == ctw_pkg::MON_RUN) && comm_exp && !any_xchg && !deact && !wdg_mode
      |=> q.red && !q.wdg_rst && !q.dstb && !q.pstb && (q.block == $past(q.block)))
    else $error("Reset issued outside watchdog mode.");

  a_wdg_mode_sel: assert property (
    (q.mon == ctw_pkg::MON_RUN) && comm_exp && !any_xchg && !deact
      |=> q.wdg_rst == $past(q.always_on || (q.p0gate && param_port_bit0)))
    else $error("Watchdog mode did not follow the configuration flags.");

  a_red_hold: assert property (
    q.red && !any_xchg && !deact && !wdg_fire |=> q.red)
    else $error("Red indicator cleared without an exchange.");

  a_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("Bus slave stalled or answered an error.");

  c_led_lit:     cover property ($rose(q.red));
  c_comm_reset:  cover property (comm_fire ##1 q.wdg_rst);
  c_tog_reset:   cover property (tog_fire ##1 q.wdg_rst);
  c_block_freed: cover property (q.block ##1 !q.block);
  c_plain_red:   cover property (comm_exp && !wdg_mode ##1 q.red);

endmodule

`default_nettype wire

// [include/ctw_pkg.sv]
// Package of constants and types for the communication and toggle watchdog block.
// Assumes a 125 MHz system clock and word-aligned single AHB-Lite transfers.
// Functional notes
// - Active monitor lights red indicator when no exchange is processed beyond timeout; in watchdog mode the code forces reset and leaves red off.
// - Exchange or parameter write after a fault restarts timer, turns red off.
// - Monitor starts at first parameter write with nonzero slave address.
// - Chip reset or address deletion deactivates the monitor until reactivated.
// - Watchdog mode when always-on flag set, or port0 flag and port bit 0.
// - Timeout in watchdog mode forces reset, strobes, exchange block, initialization.
// - After watchdog reset, data exchange refused until a parameter write arrives.
// - Toggle watchdog enables at first data output with nonzero slave address.
// - Chip reset or address deletion disables the toggle watchdog.
// - Toggle watchdog acts only in nibble profile, nibble select set, watchdog mode.
// - No selector change within toggle timeout triggers the same forced reset.

package ctw_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // Control register fields.
  localparam int unsigned CTRL_ALWAYS_BIT = 0;
  localparam int unsigned CTRL_P0GATE_BIT = 1;
  localparam int unsigned CTRL_NIBBLE_BIT = 2;
  localparam int unsigned CTRL_PROF_LSB   = 4;
  localparam int unsigned CTRL_ADDR_LSB   = 8;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // Status register fields.
  localparam int unsigned ST_MON_RUN_BIT  = 0;
  localparam int unsigned ST_FAULT_BIT    = 1;
  localparam int unsigned ST_WDG_MODE_BIT = 2;
  localparam int unsigned ST_TOG_EN_BIT   = 3;
  localparam int unsigned ST_TOG_ACT_BIT  = 4;
  localparam int unsigned ST_BLOCK_BIT    = 5;
  localparam int unsigned ST_LAST_TOG_BIT = 6;

  // Timing, in microseconds or percent, and the clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam int unsigned COMM_TIMEOUT_US = 40960;
  localparam int unsigned COMM_TOL_PCT    = 5;
  localparam int unsigned TOG_TIMEOUT_US  = 327000;
  localparam int unsigned TOG_TOL_US      = 16000;

  // The communication timeout must be exceeded, so its count fires one cycle past the nominal time.
  localparam int unsigned COMM_TIMEOUT_CYC =
    COMM_TIMEOUT_US * 1000 / (CLK_PERIOD_PS / 1000) + 1;
  localparam int unsigned TOG_TIMEOUT_CYC  =
    TOG_TIMEOUT_US * 1000 / (CLK_PERIOD_PS / 1000);

  // Monitor states, Gray coded along off, run, fault.
  typedef enum logic [1:0] {
    MON_OFF   = 2'b00,
    MON_RUN   = 2'b01,
    MON_FAULT = 2'b11
  } ctw_mon_state_t;

endpackage

// [hw/ctw_timer.sv]
// Restartable timeout counter that pulses once when its limit is reached.
// Assumes run and restart are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module ctw_timer #(
  parameter int unsigned LIMIT = 16,
  parameter int unsigned WIDTH = $clog2(LIMIT + 1)
) (
  input  wire logic clk,     // System clock.
  input  wire logic rst_n,   // Asynchronous reset, active low.
  input  wire logic run,     // Count while high, clear while low.
  input  wire logic restart, // Clear the count this cycle.
  output var  logic expire   // One-cycle pulse LIMIT cycles after the last clear.
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             exp;
  } ctw_tmr_st_t;

  localparam logic [WIDTH-1:0] LIM   = WIDTH'(LIMIT);
  localparam logic [WIDTH-1:0] LIM_1 = WIDTH'(LIMIT - 1);

  ctw_tmr_st_t q;
  ctw_tmr_st_t d;

  always_comb begin
    d     = q;
    d.exp = 1'b0;
    if (restart || !run) begin
      d.cnt = '0;
    end else if (q.cnt != LIM) begin
      d.cnt = q.cnt + 1'b1;
      d.exp = (q.cnt == LIM_1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expire = q.exp;

endmodule

`default_nettype wire

// [verification/ctw_master_model.sv]
// Behavioural field-bus master that hands processed-request pulses to the block.
// Assumes the bench calls its tasks from one process, right after hclk edges.
`timescale 1ns/100ps
`default_nettype none

module ctw_master_model (
  input  wire logic hclk,              // System clock.
  output var  logic data_xchg_evt,     // Data exchange pulse.
  output var  logic nibble_toggle_bit, // Selector bit of the exchange.
  output var  logic param_write_evt    // Parameter write pulse.
);
  logic sel_q;

  initial begin
    data_xchg_evt = 1'b0;
    param_write_evt = 1'b0;
    nibble_toggle_bit = 1'b1;
    sel_q = 1'b0;
  end

  // selector alternation: the bit flips between nibbles when alt is set.
  task automatic xchg(input logic alt);
    @(posedge hclk);
    sel_q = alt ? ~sel_q : sel_q;
    data_xchg_evt <= 1'b1;
    nibble_toggle_bit <= sel_q;
    @(posedge hclk);
    data_xchg_evt <= 1'b0;
    nibble_toggle_bit <= ~sel_q;
  endtask

  // parameter write: one-cycle pulse that lifts the exchange block after a forced reset.
  task automatic param();
    @(posedge hclk);
    param_write_evt <= 1'b1;
    @(posedge hclk);
    param_write_evt <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the communication and toggle watchdog block.
// Assumes one AHB-Lite slave and the field-bus master model, all on hclk.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int COMM = 20;
  localparam int TOG  = 40;
  logic        hclk       = 1'b0;
  logic        hresetn    = 1'b0;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = 32'h0;
  logic        del_evt    = 1'b0;
  logic        crst_evt   = 1'b0;
  logic        p0         = 1'b0;
  logic [2:0]  hsize      = 3'h0;
  logic        stb_ok     = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        xchg_evt;
  logic        tog_bit;
  logic        param_evt;
  logic        red;
  logic        wdg_pulse;
  logic        dstb;
  logic        pstb;
  logic        blk;
  int          err_count  = 0;
  int          num_checks = 0;
  int          pulses     = 0;
  int          cyc        = 0;
  int          t_pulse    = 0;
  int          t0;

  always #4 hclk = ~hclk;

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (wdg_pulse === 1'b1) begin
      pulses <= pulses + 1;
      t_pulse <= cyc;
      stb_ok <= dstb && pstb && !red;
    end
  end

  ctw_watchdog #(.COMM_CYC(COMM), .TOG_CYC(TOG)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .data_xchg_evt(xchg_evt), .nibble_toggle_bit(tog_bit), .param_write_evt(param_evt),
    .addr_delete_evt(del_evt), .chip_reset_evt(crst_evt), .param_port_bit0(p0),
    .red_fault_indicator(red), .wdg_reset_pulse(wdg_pulse), .data_strobe(dstb),
    .param_strobe(pstb), .xchg_block(blk));

  ctw_master_model u_master (
    .hclk(hclk), .data_xchg_evt(xchg_evt), .nibble_toggle_bit(tog_bit),
    .param_write_evt(param_evt));

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Waits for red (pulse low) or a new forced reset (pulse high), bounded.
  task automatic wait_for(input logic pulse, input int p);
    for (int i = 0; pulse ? (pulses == p) : (red !== 1'b1); i++) begin
      if (i == 2000) begin
        err_count++;
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    wait_for_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_for_ready();
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic wait_for_ready();
    @(posedge hclk);
    for (int i = 0; hreadyout !== 1'b1; i++) begin
      if (i == 50) begin
        err_count++;
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask

  function automatic logic [31:0] ctl(input logic [4:0] a, input logic [3:0] pr,
                                      input logic [2:0] f);
    return {19'h0, a, pr, 1'b0, f};
  endfunction

  task automatic evt_pulse(input logic del);
    @(posedge hclk);
    del_evt <= del;
    crst_evt <= !del;
    @(posedge hclk);
    del_evt <= 1'b0;
    crst_evt <= 1'b0;
  endtask

  task automatic t_regs();
    ahb(1'b0, ctw_pkg::CTRL_OFS, 32'h0);
    chk("ctrl reset", ctw_pkg::CTRL_RESET, rd);
    ahb(1'b0, ctw_pkg::STATUS_OFS, 32'h0);
    chk("status reset", 32'h0, rd);
    ahb(1'b1, 8'h08, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h08, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, ctw_pkg::CTRL_OFS, 32'h0000_1F57);
    ahb(1'b0, ctw_pkg::CTRL_OFS, 32'h0);
    chk("ctrl rw", 32'h0000_1F57, rd);
  endtask

  task automatic t_monitor();
    int p;
    int dt;
    int hi;
    evt_pulse(1'b0);
    p = pulses;
    ahb(1'b1, ctw_pkg::CTRL_OFS, ctl(5'h03, 4'h0, 3'h0));
    u_master.param();
    t0 = cyc;
    wait_for(1'b0, 0);
    dt = cyc - t0;
    hi = COMM * (100 + ctw_pkg::COMM_TOL_PCT) / 100 + 4;
    chk("red delay ok", 32'h1, 32'(dt > COMM && dt <= hi));
    chk("no reset", p, pulses);
    chk("block", 32'h0, 32'(blk));
    u_master.xchg(1'b0);
    repeat (2) @(posedge hclk);
    chk("red off", 32'h0, 32'(red));
    evt_pulse(1'b0);
    repeat (2 * COMM) @(posedge hclk);
    chk("red after reset", 32'h0, 32'(red));
  endtask

  task automatic t_inactive(input logic [4:0] a, input logic del);
    ahb(1'b1, ctw_pkg::CTRL_OFS, ctl(a, 4'h0, 3'h0));
    u_master.param();
    if (del) evt_pulse(1'b1);
    repeat (2 * COMM) @(posedge hclk);
    chk("red idle", 32'h0, 32'(red));
    ahb(1'b0, ctw_pkg::STATUS_OFS, 32'h0);
    chk("monitor off", 32'h0, 32'(rd[ctw_pkg::ST_MON_RUN_BIT]));
  endtask

  task automatic t_wdg(input logic [2:0] f, input logic pv, input logic rst);
    int p;
    evt_pulse(1'b0);
    p = pulses;
    p0 <= pv;
    ahb(1'b1, ctw_pkg::CTRL_OFS, ctl(5'h03, 4'h0, f));
    u_master.param();
    wait_for(rst, p);
    repeat (2) @(posedge hclk);
    chk("reset count", p + 32'(rst), pulses);
    if (rst) begin
      chk("strobes", 32'h1, 32'(stb_ok));
      chk("block set", 32'h1, 32'(blk));
      u_master.xchg(1'b0);
      repeat (2) @(posedge hclk);
      chk("block held", 32'h1, 32'(blk));
      u_master.param();
      repeat (2) @(posedge hclk);
      chk("block clear", 32'h0, 32'(blk));
    end
    evt_pulse(1'b0);
  endtask

  task automatic t_toggle(input logic nib, input logic [3:0] pr);
    int p;
    int dt;
    int hi;
    evt_pulse(1'b0);
    ahb(1'b1, ctw_pkg::CTRL_OFS, ctl(5'h03, pr, {nib, 2'b01}));
    u_master.param();
    p = pulses;
    u_master.xchg(1'b1);
    ahb(1'b0, ctw_pkg::STATUS_OFS, 32'h0);
    chk("toggle enabled", 32'h1, 32'(rd[ctw_pkg::ST_TOG_EN_BIT]));
    repeat (30) u_master.xchg(1'b1);
    chk("toggling kept", p, pulses);
    t0 = cyc;
    for (int i = 0; i < 40 && pulses == p; i++) u_master.xchg(1'b0);
    chk("toggle reset", p + 32'(nib && pr == 4'h5), pulses);
    if (nib && pr == 4'h5) begin
      dt = t_pulse - t0;
      hi = TOG * (ctw_pkg::TOG_TIMEOUT_US + ctw_pkg::TOG_TOL_US) / ctw_pkg::TOG_TIMEOUT_US + 4;
      chk("toggle delay ok", 32'h1, 32'(dt > TOG && dt <= hi));
      chk("toggle strobes", 32'h1, 32'(stb_ok));
    end
  endtask

  initial begin
    #400000;
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    chk("red at reset", 32'h0, 32'(red));
    t_regs();
    t_monitor();
    t_inactive(5'h00, 1'b0);
    t_inactive(5'h03, 1'b1);
    t_wdg(3'b001, 1'b0, 1'b1);
    t_wdg(3'b010, 1'b1, 1'b1);
    t_wdg(3'b010, 1'b0, 1'b0);
    t_toggle(1'b0, 4'h5);
    t_toggle(1'b1, 4'h0);
    t_toggle(1'b1, 4'h5);
    end_of_test();
  end
endmodule

`default_nettype wire
